// ==== mxo_exec.sv ====
`timescale 1ns/10ps
`default_nettype none
module mxo_exec (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire mxo_pkg::mxo_op_t op_i, // Operation, valid when op_valid_i
   input wire logic op_valid_i, // Issue strobe, ignored while busy_o
   input wire logic [7:0] imm_i, // Immediate operand
   input wire logic [5:0] file_addr_i, // File register 0..63
   input wire logic dest_i, // 0: accumulator, 1: file register
   input wire logic [7:0] file_rdata_i, // File register read data, same cycle
   input wire logic [7:0] table_high_pointer_i, // Table pointer register
   input wire logic [13:0] rom_data_i, // ROM word, same cycle as address
   output logic [8:0] rom_addr_o, // ROM table address
   output logic rom_rd_o, // ROM read request
   output logic [7:0] accumulator_o, // Accumulator
   output logic zero_flag_o, // Zero flag
   output logic digit_carry_flag_o, // Digit carry flag
   output logic carry_flag_o, // Carry flag
   output logic [7:0] timer0_mode_reg_o, // Timer0 mode register
   output logic [5:0] table_high_data_o, // Table high data
   output logic file_we_o, // File register write pulse
   output logic [5:0] file_waddr_o, // File write address
   output logic [7:0] file_wdata_o, // File write data
   output logic busy_o // Table read in progress
);
   import mxo_pkg::*;

   // All block state apart from the table sequencer
   typedef struct packed {
      logic [7:0] acc;
      logic z;
      logic dc;
      logic c;
      logic [7:0] timer0_mode_reg;
      logic [5:0] table_high_data;
      logic [8:0] rom_addr;
      logic rom_rd;
      logic fwe;
      logic [5:0] fwaddr;
      logic [7:0] fwdata;
      logic busy;
   } mxo_state_t;

   mxo_state_t s_r; // Registered state
   mxo_state_t s_nxt; // Next state

   logic [7:0] alu_a; // ALU first operand
   logic [7:0] alu_b; // ALU second operand
   logic alu_sub; // Subtract select
   logic [7:0] alu_res; // ALU result
   logic alu_z; // ALU zero
   logic alu_dc; // ALU digit carry
   logic alu_c; // ALU carry
   logic tbl_busy; // Sequencer in capture cycle
   logic tbl_done; // Capture done pulse
   logic issue; // Accepted operation
   logic tbl_start; // Table read start

   // Accepted unless the table capture cycle is running
   assign issue = op_valid_i && !tbl_busy;
   // Table read begins on an accepted issue
   assign tbl_start = issue && (op_i == MXO_OP_ROM_TABLE_READ);

   // Operand selection for the shared ALU
   always_comb begin
      alu_a = s_r.acc;
      alu_b = imm_i;
      alu_sub = 1'b0;
      unique case (op_i)
         MXO_OP_SUB_ACC_FROM_IMM: begin
            // Immediate on the minuend side
            alu_a = imm_i;
            alu_b = s_r.acc;
            alu_sub = 1'b1;
         end
         MXO_OP_XOR_ACC_WITH_FILE: begin
            // File register against the accumulator
            alu_b = file_rdata_i;
         end
         default: begin
            // Immediate against the accumulator
            alu_b = imm_i;
         end
      endcase
   end

   // Arithmetic unit
   mxo_alu u_alu (
      .a_i(alu_a),
      .b_i(alu_b),
      .sub_i(alu_sub),
      .res_o(alu_res),
      .z_o(alu_z),
      .dc_o(alu_dc),
      .c_o(alu_c)
   );

   // Table read sequencer
   mxo_tbl u_tbl (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(tbl_start),
      .busy_o(tbl_busy),
      .done_o(tbl_done)
   );

   // Next-state logic
   always_comb begin
      s_nxt = s_r;
      s_nxt.rom_rd = 1'b0;
      s_nxt.fwe = 1'b0;
      s_nxt.busy = tbl_start;
      // Capture the ROM word in the second table cycle
      if (tbl_busy) begin
         s_nxt.acc = rom_data_i[7:0];
         s_nxt.table_high_data = rom_data_i[13:8];
      end else if (issue) begin
         unique case (op_i)
            MXO_OP_SUB_ACC_FROM_IMM: begin
               // Difference and all three flags
               s_nxt.acc = alu_res;
               s_nxt.z = alu_z;
               s_nxt.dc = alu_dc;
               s_nxt.c = alu_c;
            end
            MXO_OP_ROM_TABLE_READ: begin
               // Address registered now, on rom_addr_o next cycle, word captured in that cycle
               s_nxt.rom_addr = {table_high_pointer_i[0], s_r.acc};
               s_nxt.rom_rd = 1'b1;
            end
            MXO_OP_LOAD_TIMER0_MODE: begin
               // Flags untouched
               s_nxt.timer0_mode_reg = s_r.acc;
            end
            MXO_OP_READ_TIMER0_MODE: begin
               // Flags untouched
               s_nxt.acc = s_r.timer0_mode_reg;
            end
            MXO_OP_XOR_ACC_WITH_FILE: begin
               // Zero flag only
               s_nxt.z = alu_z;
               // Destination bit picks accumulator or file
               if (dest_i) begin
                  s_nxt.fwe = 1'b1;
                  s_nxt.fwaddr = file_addr_i;
                  s_nxt.fwdata = alu_res;
               end else begin
                  s_nxt.acc = alu_res;
               end
            end
            MXO_OP_XOR_IMM_WITH_ACC: begin
               // Zero flag only
               s_nxt.acc = alu_res;
               s_nxt.z = alu_z;
            end
            default: begin
               // No operation: state kept
               s_nxt.rom_rd = 1'b0;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         s_r <= '{acc: MXO_ACC_RST, z: 1'b0, dc: 1'b0, c: 1'b0, timer0_mode_reg: MXO_TIMER0_MODE_REG_RST,
                  table_high_data: MXO_TABLE_HIGH_DATA_RST, rom_addr: 9'h000, rom_rd: 1'b0, fwe: 1'b0,
                  fwaddr: 6'h00, fwdata: 8'h00, busy: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign accumulator_o = s_r.acc;
   assign zero_flag_o = s_r.z;
   assign digit_carry_flag_o = s_r.dc;
   assign carry_flag_o = s_r.c;
   assign timer0_mode_reg_o = s_r.timer0_mode_reg;
   assign table_high_data_o = s_r.table_high_data;
   assign rom_addr_o = s_r.rom_addr;
   assign rom_rd_o = s_r.rom_rd;
   assign file_we_o = s_r.fwe;
   assign file_waddr_o = s_r.fwaddr;
   assign file_wdata_o = s_r.fwdata;
   assign busy_o = s_r.busy;

   // Immediate subtract result one cycle later
   a_sub_result: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_SUB_ACC_FROM_IMM |=>
      accumulator_o == 8'($past(imm_i) - $past(s_r.acc)))
      else $error("subtract result wrong");

   // Carry set when the subtraction needs no borrow
   a_sub_carry: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_SUB_ACC_FROM_IMM |=>
      carry_flag_o == ($past(imm_i) >= $past(s_r.acc)))
      else $error("subtract carry wrong");

   // Digit carry set when the low nibble needs no borrow
   a_sub_digit: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_SUB_ACC_FROM_IMM |=>
      digit_carry_flag_o == ($past(imm_i[3:0]) >= $past(s_r.acc[3:0])))
      else $error("subtract digit carry wrong");

   // Zero after subtract when both operands matched
   a_sub_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_SUB_ACC_FROM_IMM |=>
      zero_flag_o == ($past(imm_i) == $past(s_r.acc)))
      else $error("subtract zero flag wrong");

   // Table address is pointer bit 0 above the accumulator
   a_table_addr: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      tbl_start |=> rom_rd_o && rom_addr_o == {$past(table_high_pointer_i[0]), $past(s_r.acc)})
      else $error("table address wrong");

   // High ROM bits land in table high data, carry kept
   a_table_data: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      tbl_start |=> ##1 table_high_data_o == $past(rom_data_i[13:8]) && $stable(carry_flag_o))
      else $error("table high data wrong");

   // Low ROM byte lands in the accumulator, flags kept
   a_table_acc: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      tbl_start |=> ##1 tbl_done && accumulator_o == $past(rom_data_i[7:0])
      && $stable(zero_flag_o) && $stable(digit_carry_flag_o))
      else $error("table accumulator wrong");

   // Busy stands for the capture cycle only
   a_table_busy: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      tbl_start |=> busy_o ##1 !busy_o)
      else $error("table busy length wrong");

   // Nothing is taken while the capture cycle runs
   a_busy_refuse: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      tbl_busy |=> !file_we_o && !rom_rd_o && $stable(timer0_mode_reg_o))
      else $error("operation taken while busy");

   // Timer0 mode load keeps the zero flag
   a_timer0_mode_reg_load: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_LOAD_TIMER0_MODE |=> timer0_mode_reg_o == $past(s_r.acc) && $stable(zero_flag_o))
      else $error("timer mode load wrong");

   // Timer0 mode register moves only on its load
   a_timer0_mode_reg_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !(issue && op_i == MXO_OP_LOAD_TIMER0_MODE) |=> $stable(timer0_mode_reg_o))
      else $error("timer mode changed without load");

   // Timer0 mode read keeps the carry flag
   a_timer0_mode_reg_read: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_READ_TIMER0_MODE |=> accumulator_o == $past(s_r.timer0_mode_reg) && $stable(carry_flag_o))
      else $error("timer mode read wrong");

   // File XOR written back, accumulator kept
   a_xor_file: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_XOR_ACC_WITH_FILE && dest_i |=>
      file_we_o && file_wdata_o == ($past(s_r.acc) ^ $past(file_rdata_i)) && $stable(accumulator_o))
      else $error("file xor wrong");

   // File XOR into the accumulator, no file write
   a_xor_acc: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_XOR_ACC_WITH_FILE && !dest_i |=>
      accumulator_o == ($past(s_r.acc) ^ $past(file_rdata_i)) && !file_we_o && $stable(carry_flag_o))
      else $error("file xor to accumulator wrong");

   // File XOR zero flag follows the written value
   a_xor_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_XOR_ACC_WITH_FILE && dest_i |=>
      zero_flag_o == ($past(s_r.acc) == $past(file_rdata_i)) && file_waddr_o == $past(file_addr_i)
      && $stable(digit_carry_flag_o))
      else $error("file xor zero flag wrong");

   // Immediate XOR into the accumulator, carry kept
   a_xor_imm: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_XOR_IMM_WITH_ACC |=>
      accumulator_o == ($past(s_r.acc) ^ $past(imm_i)) && zero_flag_o == (accumulator_o == 8'h00)
      && $stable(carry_flag_o))
      else $error("immediate xor wrong");

   // Immediate XOR leaves digit carry and the file alone
   a_xor_imm_dc: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_XOR_IMM_WITH_ACC |=>
      $stable(digit_carry_flag_o) && !file_we_o)
      else $error("immediate xor side effect");

   // Main scenarios
   c_table_read: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) tbl_start ##2 !tbl_busy);
   c_sub_borrow: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_SUB_ACC_FROM_IMM ##1 !carry_flag_o);
   c_xor_file: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) file_we_o);
   c_busy_refuse: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) tbl_busy && op_valid_i);
   c_sub_zero: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      issue && op_i == MXO_OP_SUB_ACC_FROM_IMM ##1 zero_flag_o);
endmodule : mxo_exec
`default_nettype wire

// ==== mxo_pkg.sv ====
package mxo_pkg;
   // Operation codes presented by the sequencer
   typedef enum logic [2:0] {
      MXO_OP_NONE,
      MXO_OP_SUB_ACC_FROM_IMM,
      MXO_OP_ROM_TABLE_READ,
      MXO_OP_LOAD_TIMER0_MODE,
      MXO_OP_READ_TIMER0_MODE,
      MXO_OP_XOR_ACC_WITH_FILE,
      MXO_OP_XOR_IMM_WITH_ACC
   } mxo_op_t;
   // Datapath widths
   localparam int MXO_DATA_W = 8;
   localparam int MXO_ROM_W = 14;
   localparam int MXO_ROM_AW = 9;
   localparam int MXO_FILE_AW = 6;
   localparam int MXO_HIGH_W = 6;
   // Reset values
   localparam logic [7:0] MXO_ACC_RST = 8'h00;
   localparam logic [7:0] MXO_TIMER0_MODE_REG_RST = 8'h00;
   localparam logic [5:0] MXO_TABLE_HIGH_DATA_RST = 6'h00;
   localparam logic [7:0] MXO_TABLE_HIGH_POINTER_RST = 8'h00;
   // Instruction cycle counts
   localparam int MXO_TABLE_CYCLES = 2;
endpackage : mxo_pkg

// ==== mxo_alu.sv ====
`timescale 1ns/10ps
`default_nettype none
// Subtract and exclusive-OR arithmetic with flag generation
module mxo_alu (
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic sub_i,
   output logic [7:0] res_o,
   output logic z_o,
   output logic dc_o,
   output logic c_o
);
   import mxo_pkg::*;
   logic [8:0] diff; // Full difference with borrow-out complement
   logic [4:0] ldiff; // Low nibble difference
   // a - b as a + ~b + 1; carry out means no borrow
   always_comb begin
      diff = {1'b0, a_i} + {1'b0, ~b_i} + 9'h001;
      ldiff = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + 5'h01;
      res_o = sub_i ? diff[7:0] : (a_i ^ b_i);
      z_o = (res_o == 8'h00);
      dc_o = ldiff[4];
      c_o = diff[8];
   end
endmodule : mxo_alu
`default_nettype wire

// ==== mxo_tbl.sv ====
`timescale 1ns/10ps
`default_nettype none
// Two-cycle table read sequencer: issue address, then capture word
module mxo_tbl (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   output logic busy_o,
   output logic done_o
);
   import mxo_pkg::*;
   typedef enum logic {MXO_T_IDLE, MXO_T_WAIT} mxo_tstate_t;
   typedef struct packed {
      mxo_tstate_t st;
      logic done;
   } mxo_tbl_t;
   mxo_tbl_t q_r; // State
   mxo_tbl_t q_nxt; // Next state
   // Next-state logic
   always_comb begin
      q_nxt = q_r;
      q_nxt.done = 1'b0;
      unique case (q_r.st)
         MXO_T_IDLE: begin
            if (start_i) begin
               q_nxt.st = MXO_T_WAIT;
            end
         end
         MXO_T_WAIT: begin
            q_nxt.st = MXO_T_IDLE;
            q_nxt.done = 1'b1;
         end
      endcase
   end
   // Register
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         q_r <= '{st: MXO_T_IDLE, done: 1'b0};
      end else begin
         q_r <= q_nxt;
      end
   end
   assign busy_o = (q_r.st == MXO_T_WAIT);
   assign done_o = q_r.done;
endmodule : mxo_tbl
`default_nettype wire

// ==== mxo_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Program ROM and file register bank facing the execution block
module mxo_mem_model (
   input wire logic clk_i,
   input wire logic [8:0] rom_addr_i, // Table address
   input wire logic rom_rd_i, // Table read strobe
   output logic [13:0] rom_data_o, // ROM word
   input wire logic [5:0] file_addr_i, // Read index
   output logic [7:0] file_rdata_o, // Read data, same cycle
   input wire logic file_we_i, // Write pulse
   input wire logic [5:0] file_waddr_i, // Write index
   input wire logic [7:0] file_wdata_i // Write data
);
   logic [7:0] mem [64]; // File registers
   logic [13:0] last_r; // Last word on the ROM bus
   // Fixed pattern while reading; bus flips every cycle otherwise
   assign rom_data_o = rom_rd_i ? {rom_addr_i[5:0] ^ 6'h15, rom_addr_i[7:0] ^ 8'hC3} : ~last_r;
   assign file_rdata_o = mem[file_addr_i];
   // Preset contents: register n holds 3n
   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = 8'(i * 3);
      end
      last_r = 14'h0000;
   end
   // Writes land on the clock edge of the pulse
   always @(posedge clk_i) begin
      last_r <= rom_data_o;
      if (file_we_i) begin
         mem[file_waddr_i] <= file_wdata_i;
      end
   end
endmodule : mxo_mem_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import mxo_pkg::*;
   // One ordinary case: operation, operands, expected accumulator and {zero, dc, carry}
   typedef struct packed {
      mxo_op_t op;
      logic [7:0] imm;
      logic d;
      logic [7:0] acc;
      logic [2:0] flg;
   } mxo_row_t;
   logic sys_clk_i = 0, sys_rst_i = 1, op_valid_i = 0, dest_i = 0, rom_rd_o, file_we_o, busy_o;
   mxo_op_t op_i = MXO_OP_NONE;
   logic [7:0] imm_i = 8'h00, table_high_pointer_i = 8'h00, file_rdata_i, accumulator_o, timer0_mode_reg_o;
   logic [5:0] file_addr_i = 6'h3F, file_waddr_o, table_high_data_o;
   logic [13:0] rom_data_i;
   logic [8:0] rom_addr_o;
   logic [7:0] file_wdata_o;
   logic zero_flag_o, digit_carry_flag_o, carry_flag_o;
   int n_errors = 0, checks = 0, cyc = 0;
   localparam mxo_row_t ROWS [14] = '{
      '{MXO_OP_XOR_IMM_WITH_ACC, 8'hF0, 0, 8'hF0, 3'h0}, '{MXO_OP_XOR_IMM_WITH_ACC, 8'hA5, 0, 8'h55, 3'h0},
      '{MXO_OP_SUB_ACC_FROM_IMM, 8'h56, 0, 8'h01, 3'h3}, '{MXO_OP_SUB_ACC_FROM_IMM, 8'h00, 0, 8'hFF, 3'h0},
      '{MXO_OP_SUB_ACC_FROM_IMM, 8'hFF, 0, 8'h00, 3'h7}, '{MXO_OP_XOR_IMM_WITH_ACC, 8'h00, 0, 8'h00, 3'h7},
      '{MXO_OP_XOR_IMM_WITH_ACC, 8'h3C, 0, 8'h3C, 3'h3}, '{MXO_OP_LOAD_TIMER0_MODE, 8'h00, 0, 8'h3C, 3'h3},
      '{MXO_OP_SUB_ACC_FROM_IMM, 8'h40, 0, 8'h04, 3'h1}, '{MXO_OP_READ_TIMER0_MODE, 8'h00, 0, 8'h3C, 3'h1},
      '{MXO_OP_XOR_ACC_WITH_FILE, 8'h00, 0, 8'h81, 3'h1}, '{MXO_OP_XOR_ACC_WITH_FILE, 8'h00, 1, 8'h81, 3'h1},
      '{MXO_OP_XOR_ACC_WITH_FILE, 8'h00, 0, 8'hBD, 3'h1}, '{MXO_OP_NONE, 8'h00, 0, 8'hBD, 3'h1}};
   // Clock of 5 ns
   always #2.5 sys_clk_i = ~sys_clk_i;
   mxo_exec uut (.sys_clk_i, .sys_rst_i, .op_i, .op_valid_i, .imm_i, .file_addr_i, .dest_i, .file_rdata_i,
      .table_high_pointer_i, .rom_data_i, .rom_addr_o, .rom_rd_o, .accumulator_o, .zero_flag_o,
      .digit_carry_flag_o, .carry_flag_o, .timer0_mode_reg_o, .table_high_data_o, .file_we_o,
      .file_waddr_o, .file_wdata_o, .busy_o);
   mxo_mem_model mem (.clk_i(sys_clk_i), .rom_addr_i(rom_addr_o), .rom_rd_i(rom_rd_o), .rom_data_o(rom_data_i),
      .file_addr_i(file_addr_i), .file_rdata_o(file_rdata_i), .file_we_i(file_we_o),
      .file_waddr_i(file_waddr_o), .file_wdata_i(file_wdata_o));
   // Compare one observed value
   task automatic chk(input string nm, input logic [13:0] exp, input logic [13:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Drive one operation for one cycle, then look just after the taking edge
   task automatic issue(input mxo_op_t op, input logic [7:0] imm, input logic d);
      @(posedge sys_clk_i);
      op_valid_i <= 1'b1;
      op_i <= op;
      imm_i <= imm;
      dest_i <= d;
      @(posedge sys_clk_i);
      op_valid_i <= 1'b0;
      #1;
   endtask : issue
   // Architectural state against expectations
   task automatic state(input logic [7:0] acc, input logic [2:0] flg);
      chk("acc", 14'(acc), 14'(accumulator_o));
      chk("flags", 14'(flg), 14'({zero_flag_o, digit_carry_flag_o, carry_flag_o}));
   endtask : state
   // Counts, verdict and end of run
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   // Hang guard
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         give_verdict();
      end
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      #1;
      state(8'h00, 3'h0);
      for (int i = 0; i < 14; i++) begin
         issue(ROWS[i].op, ROWS[i].imm, ROWS[i].d);
         state(ROWS[i].acc, ROWS[i].flg);
         chk("timer0_mode_reg", 14'(i >= 7 ? 8'h3C : 8'h00), 14'(timer0_mode_reg_o));
         chk("file_we", 14'(ROWS[i].d), 14'(file_we_o));
         if (ROWS[i].d) chk("file_wdata", 14'h3F3C, {file_waddr_o, file_wdata_o});
      end
      // Back-to-back: xor to zero, then subtract the zeroed accumulator from the immediate
      @(posedge sys_clk_i);
      op_valid_i <= 1'b1;
      op_i <= MXO_OP_XOR_IMM_WITH_ACC;
      imm_i <= 8'hBD;
      @(posedge sys_clk_i);
      op_i <= MXO_OP_SUB_ACC_FROM_IMM;
      imm_i <= 8'h01;
      #1 state(8'h00, 3'h5);
      @(posedge sys_clk_i);
      op_valid_i <= 1'b0;
      #1 state(8'h01, 3'h3);
      // Reset in mid-run clears all execution block state, not the file registers
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      #1 state(8'h00, 3'h0);
      chk("timer0_mode_reg", 14'h0000, 14'(timer0_mode_reg_o));
      // Table read with flags set, pointer bits above bit 0 ignored, issue in busy cycle refused
      issue(MXO_OP_SUB_ACC_FROM_IMM, 8'h35, 1'b0);
      issue(MXO_OP_XOR_IMM_WITH_ACC, 8'h01, 1'b0);
      state(8'h34, 3'h3);
      @(posedge sys_clk_i);
      op_valid_i <= 1'b1;
      op_i <= MXO_OP_ROM_TABLE_READ;
      imm_i <= 8'h00;
      table_high_pointer_i <= 8'h03;
      @(posedge sys_clk_i);
      op_i <= MXO_OP_XOR_IMM_WITH_ACC;
      imm_i <= 8'hFF;
      #1 chk("rom_rd busy", 14'h0003, 14'({rom_rd_o, busy_o}));
      chk("rom_addr", 14'h0134, 14'(rom_addr_o));
      @(posedge sys_clk_i);
      op_valid_i <= 1'b0;
      #1 state(8'hF7, 3'h3);
      chk("table_high_data", 14'h0021, 14'(table_high_data_o));
      @(posedge sys_clk_i);
      #1 state(8'hF7, 3'h3);
      chk("busy", 14'h0000, 14'(busy_o));
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
